// File: verilog/ip_ach_cmp_map.vh
// register offsets, field positions, reset values and fixed codes of the ip/ach comparator
`ifndef IP_ACH_CMP_MAP_VH
`define IP_ACH_CMP_MAP_VH

// register byte offsets
`define REG_CTRL        8'h00
`define REG_FIRST       8'h04
`define REG_POSITION    8'h08
`define REG_SUM_LOC     8'h0C
`define REG_WIDE_BASE   8'h10
`define REG_WIDE_LAST   8'h3C
`define REG_STATUS      8'h40

// wide word indices (offset - base) / 4
`define WIDE_SECOND_VAL 4'h0
`define WIDE_SECOND_MSK 4'h2
`define WIDE_FLOW_VAL   4'h4
`define WIDE_FLOW_MSK   4'h8
`define WIDE_WORDS      12

// control word fields
`define CTRL_MODE_LSB   0
`define CTRL_NEXT_LSB   4
`define CTRL_FSEL_LSB   8
`define CTRL_ZERO_BIT   12
`define CTRL_FIX_BIT    13
`define CTRL_SLEN_LSB   16

// first match word fields
`define FIRST_VAL_LSB   0
`define FIRST_MSK_LSB   8
`define FIRST_POS_LSB   16

// position word fields
`define POS_SECOND_LSB  0
`define POS_FLOW_LSB    8
`define POS_HLEN_LSB    16

// reset values
`define RST_MODE        2'h0
`define RST_NEXT        3'h0
`define RST_FSEL        2'h0
`define RST_SLEN        2'h2
`define RST_HLEN        8'h00
`define RST_BYTE        8'h00
`define RST_POS5        5'h00
`define RST_POS7        7'h00
`define RST_WORD        32'h0000_0000

// comparator modes
`define MODE_IPV4       2'h0
`define MODE_IPV6       2'h1
`define MODE_OTHER32    2'h2
`define MODE_OTHER128   2'h3

// flow address select
`define FSEL_SRC        2'h0
`define FSEL_DST        2'h1
`define FSEL_EITHER     2'h2

// fixed header values
`define VER_IPV4        4'h4
`define VER_IPV6        4'h6
`define REL_VERSION     9'h000
`define REL_FLAGS       9'h006
`define REL_FRAG_LO     9'h007
`define FLOW_LEN_SHORT  9'h004
`define FLOW_LEN_LONG   9'h010

// axi responses
`define RESP_OKAY       2'h0
`define RESP_DECERR     2'h3

`endif

// File: verilog/ip_ach_next_protocol_compare.v
// ip/udp/ach next-protocol comparator stage with axi4-lite configuration registers
`include "ip_ach_cmp_map.vh"

module ip_ach_next_protocol_compare (
   // clock and reset
   input  wire        i_clk_sys,
   input  wire        i_reset,
   // axi4-lite write address
   input  wire [7:0]  i_awaddr,
   input  wire        i_awvalid,
   output reg         o_awready,
   // axi4-lite write data
   input  wire [31:0] i_wdata,
   input  wire [3:0]  i_wstrb,
   input  wire        i_wvalid,
   output reg         o_wready,
   // axi4-lite write response
   output reg  [1:0]  o_bresp,
   output reg         o_bvalid,
   input  wire        i_bready,
   // axi4-lite read address
   input  wire [7:0]  i_araddr,
   input  wire        i_arvalid,
   output reg         o_arready,
   // axi4-lite read data
   output reg  [31:0] o_rdata,
   output reg  [1:0]  o_rresp,
   output reg         o_rvalid,
   input  wire        i_rready,
   // frame byte stream from the preceding stage
   input  wire        i_frm_valid,
   input  wire [7:0]  i_frm_data,
   input  wire        i_frm_sof,
   input  wire        i_frm_eof,
   input  wire [7:0]  i_hdr_pos,
   input  wire        i_stage_sel,
   // result toward the following stage and the rewriter
   output reg         o_res_valid,
   output reg         o_proto_match,
   output reg         o_flow_match,
   output reg  [7:0]  o_next_hdr_pos,
   output reg  [2:0]  o_next_stage,
   output reg         o_sum_zero,
   output reg         o_sum_fixup,
   output reg  [7:0]  o_sum_loc,
   output reg  [1:0]  o_sum_len
);

   // configuration
   reg  [1:0]  mode_q;
   reg  [2:0]  next_stage_q;
   reg  [1:0]  fsel_q;
   reg         zero_en_q;
   reg         fixup_en_q;
   reg  [1:0]  sum_len_q;
   reg  [7:0]  first_val_q;
   reg  [7:0]  first_msk_q;
   reg  [4:0]  first_pos_q;
   reg  [6:0]  second_pos_q;
   reg  [4:0]  flow_pos_q;
   reg  [7:0]  hdr_len_q;
   reg  [7:0]  sum_loc_q;
   reg  [31:0] wide_q [0:`WIDE_WORDS-1];

   // axi write side
   reg         aw_have_q;
   reg         w_have_q;
   reg  [7:0]  awaddr_q;
   reg  [31:0] wdata_q;
   reg  [3:0]  wstrb_q;

   // frame tracking
   reg  [7:0]  cnt_q;
   reg  [7:0]  hdr_q;
   reg         act_q;
   reg         ver_bad_q;
   reg         frag_bad_q;
   reg         set1_bad_q;
   reg         set2_bad_q;
   reg         src_bad_q;
   reg         dst_bad_q;
   reg  [5:0]  status_q;

   wire [63:0]  second_val = {wide_q[`WIDE_SECOND_VAL], wide_q[`WIDE_SECOND_VAL + 4'h1]};
   wire [63:0]  second_msk = {wide_q[`WIDE_SECOND_MSK], wide_q[`WIDE_SECOND_MSK + 4'h1]};
   wire [127:0] flow_val   = {wide_q[`WIDE_FLOW_VAL], wide_q[`WIDE_FLOW_VAL + 4'h1],
                              wide_q[`WIDE_FLOW_VAL + 4'h2], wide_q[`WIDE_FLOW_VAL + 4'h3]};
   wire [127:0] flow_msk   = {wide_q[`WIDE_FLOW_MSK], wide_q[`WIDE_FLOW_MSK + 4'h1],
                              wide_q[`WIDE_FLOW_MSK + 4'h2], wide_q[`WIDE_FLOW_MSK + 4'h3]};

   // ---------------- axi4-lite write ----------------
   wire        wr_fire  = aw_have_q && w_have_q && !o_bvalid;
   wire        wr_wide  = (awaddr_q >= `REG_WIDE_BASE) && (awaddr_q <= `REG_WIDE_LAST);
   wire [3:0]  wr_index = awaddr_q[5:2] - 4'h4;
   wire        wr_known = wr_wide || (awaddr_q == `REG_CTRL) || (awaddr_q == `REG_FIRST) ||
                          (awaddr_q == `REG_POSITION) || (awaddr_q == `REG_SUM_LOC) ||
                          (awaddr_q == `REG_STATUS);
   wire [31:0] wr_bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

   // control words as seen with byte strobes merged
   wire [31:0] ctrl_now  = {14'h0000, sum_len_q, 2'h0, fixup_en_q, zero_en_q, 2'h0, fsel_q,
                            1'b0, next_stage_q, 2'h0, mode_q};
   wire [31:0] first_now = {11'h000, first_pos_q, first_msk_q, first_val_q};
   wire [31:0] pos_now   = {8'h00, hdr_len_q, 3'h0, flow_pos_q, 1'b0, second_pos_q};
   wire [31:0] ctrl_new  = (ctrl_now & ~wr_bmask) | (wdata_q & wr_bmask);
   wire [31:0] first_new = (first_now & ~wr_bmask) | (wdata_q & wr_bmask);
   wire [31:0] pos_new   = (pos_now & ~wr_bmask) | (wdata_q & wr_bmask);

   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_awready <= 1'b0;
         o_wready  <= 1'b0;
         o_bvalid  <= 1'b0;
         o_bresp   <= `RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= `RST_WORD;
         wstrb_q   <= 4'h0;
      end else begin
         // address and data are taken in either order and held until both are here
         if (o_awready && i_awvalid) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= i_awaddr;
         end else if (wr_fire) begin
            aw_have_q <= 1'b0;
         end
         if (o_wready && i_wvalid) begin
            w_have_q <= 1'b1;
            wdata_q  <= i_wdata;
            wstrb_q  <= i_wstrb;
         end else if (wr_fire) begin
            w_have_q <= 1'b0;
         end
         o_awready <= !aw_have_q && !(o_awready && i_awvalid);
         o_wready  <= !w_have_q && !(o_wready && i_wvalid);
         if (wr_fire) begin
            o_bvalid <= 1'b1;
            o_bresp  <= wr_known ? `RESP_OKAY : `RESP_DECERR;
         end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         mode_q       <= `RST_MODE;
         next_stage_q <= `RST_NEXT;
         fsel_q       <= `RST_FSEL;
         zero_en_q    <= 1'b0;
         fixup_en_q   <= 1'b0;
         sum_len_q    <= `RST_SLEN;
         first_val_q  <= `RST_BYTE;
         first_msk_q  <= `RST_BYTE;
         first_pos_q  <= `RST_POS5;
         second_pos_q <= `RST_POS7;
         flow_pos_q   <= `RST_POS5;
         hdr_len_q    <= `RST_HLEN;
         sum_loc_q    <= `RST_BYTE;
      end else if (wr_fire) begin
         if (awaddr_q == `REG_CTRL) begin
            mode_q       <= ctrl_new[`CTRL_MODE_LSB +: 2];
            next_stage_q <= ctrl_new[`CTRL_NEXT_LSB +: 3];
            fsel_q       <= ctrl_new[`CTRL_FSEL_LSB +: 2];
            zero_en_q    <= ctrl_new[`CTRL_ZERO_BIT];
            fixup_en_q   <= ctrl_new[`CTRL_FIX_BIT];
            sum_len_q    <= ctrl_new[`CTRL_SLEN_LSB +: 2];
         end
         if (awaddr_q == `REG_FIRST) begin
            first_val_q <= first_new[`FIRST_VAL_LSB +: 8];
            first_msk_q <= first_new[`FIRST_MSK_LSB +: 8];
            first_pos_q <= first_new[`FIRST_POS_LSB +: 5];
         end
         if (awaddr_q == `REG_POSITION) begin
            second_pos_q <= pos_new[`POS_SECOND_LSB +: 7];
            flow_pos_q   <= pos_new[`POS_FLOW_LSB +: 5];
            hdr_len_q    <= pos_new[`POS_HLEN_LSB +: 8];
         end
         if (awaddr_q == `REG_SUM_LOC) begin
            sum_loc_q <= (sum_loc_q & ~wr_bmask[7:0]) | (wdata_q[7:0] & wr_bmask[7:0]);
         end
      end
   end

   // wide match and mask words, one flop group per word
   genvar gi;
   generate
      for (gi = 0; gi < `WIDE_WORDS; gi = gi + 1) begin : g_wide
         always @(posedge i_clk_sys or posedge i_reset) begin
            if (i_reset) begin
               wide_q[gi] <= `RST_WORD;
            end else if (wr_fire && wr_wide && (wr_index == gi)) begin
               wide_q[gi] <= (wide_q[gi] & ~wr_bmask) | (wdata_q & wr_bmask);
            end
         end
      end
   endgenerate

   // ---------------- axi4-lite read ----------------
   reg  [31:0] rd_word;
   reg         rd_known;
   wire [3:0]  rd_index = i_araddr[5:2] - 4'h4;

   always @* begin
      rd_word  = `RST_WORD;
      rd_known = 1'b1;
      if ((i_araddr >= `REG_WIDE_BASE) && (i_araddr <= `REG_WIDE_LAST) &&
          (i_araddr[1:0] == 2'h0)) begin
         rd_word = wide_q[rd_index];
      end else begin
         case (i_araddr)
            `REG_CTRL:     rd_word = ctrl_now;
            `REG_FIRST:    rd_word = first_now;
            `REG_POSITION: rd_word = pos_now;
            `REG_SUM_LOC:  rd_word = {24'h000000, sum_loc_q};
            `REG_STATUS:   rd_word = {26'h0000000, status_q};
            default:       rd_known = 1'b0;
         endcase
      end
   end

   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b0;
         o_rdata   <= `RST_WORD;
         o_rresp   <= `RESP_OKAY;
      end else begin
         if (o_arready && i_arvalid) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= rd_word;
            o_rresp   <= rd_known ? `RESP_OKAY : `RESP_DECERR;
         end else if (o_rvalid) begin
            if (i_rready) begin
               o_rvalid <= 1'b0;
            end
         end else begin
            o_arready <= 1'b1;
         end
      end
   end

   // ---------------- header comparison ----------------
   wire [7:0] pos_now_b = i_frm_sof ? 8'h00 : cnt_q;
   wire [7:0] hdr_now   = i_frm_sof ? i_hdr_pos : hdr_q;
   wire       act_now   = i_frm_sof ? i_stage_sel : act_q;
   wire       in_hdr    = pos_now_b >= hdr_now;
   wire [8:0] rel       = {1'b0, pos_now_b} - {1'b0, hdr_now};
   wire       short_fld = (mode_q == `MODE_IPV4) || (mode_q == `MODE_OTHER32);
   wire [8:0] flow_len  = short_fld ? `FLOW_LEN_SHORT : `FLOW_LEN_LONG;
   wire [8:0] k2        = rel - {2'h0, second_pos_q};
   wire [8:0] ks        = rel - {4'h0, flow_pos_q};
   wire [8:0] kd        = ks - flow_len;
   wire       take      = i_frm_valid && in_hdr;

   wire [7:0] v2 = second_val[8 * (7 - k2[2:0]) +: 8];
   wire [7:0] m2 = second_msk[8 * (7 - k2[2:0]) +: 8];
   wire [7:0] vs = flow_val[8 * (15 - ks[3:0]) +: 8];
   wire [7:0] ms = flow_msk[8 * (15 - ks[3:0]) +: 8];
   wire [7:0] vd = flow_val[8 * (15 - kd[3:0]) +: 8];
   wire [7:0] md = flow_msk[8 * (15 - kd[3:0]) +: 8];

   wire ver_hit  = take && (rel == `REL_VERSION);
   wire ver_cur  = ver_hit && (((mode_q == `MODE_IPV4) && (i_frm_data[7:4] != `VER_IPV4)) ||
                   ((mode_q == `MODE_IPV6) && (i_frm_data[7:4] != `VER_IPV6)));
   wire frag_cur = take && (mode_q == `MODE_IPV4) &&
                   (((rel == `REL_FLAGS) && (i_frm_data[5:0] != 6'h00)) ||
                   ((rel == `REL_FRAG_LO) && (i_frm_data != 8'h00)));
   wire set1_cur = take && (rel == {4'h0, first_pos_q}) &&
                   (((i_frm_data ^ first_val_q) & first_msk_q) != 8'h00);
   wire set2_cur = take && (k2 < 9'h008) && (((i_frm_data ^ v2) & m2) != 8'h00);
   wire src_cur  = take && (ks < flow_len) && (((i_frm_data ^ vs) & ms) != 8'h00);
   wire dst_cur  = take && (kd < flow_len) && (((i_frm_data ^ vd) & md) != 8'h00);

   wire ver_bad  = (i_frm_sof ? 1'b0 : ver_bad_q) | ver_cur;
   wire frag_bad = (i_frm_sof ? 1'b0 : frag_bad_q) | frag_cur;
   wire set1_bad = (i_frm_sof ? 1'b0 : set1_bad_q) | set1_cur;
   wire set2_bad = (i_frm_sof ? 1'b0 : set2_bad_q) | set2_cur;
   wire src_bad  = (i_frm_sof ? 1'b0 : src_bad_q) | src_cur;
   wire dst_bad  = (i_frm_sof ? 1'b0 : dst_bad_q) | dst_cur;

   wire proto_ok = act_now && !ver_bad && !frag_bad && !set1_bad && !set2_bad;
   reg  flow_ok;
   always @* begin
      flow_ok = 1'b0;
      if (!short_fld || (mode_q == `MODE_IPV4)) begin
         if ((mode_q == `MODE_IPV4) || (mode_q == `MODE_IPV6)) begin
            case (fsel_q)
               `FSEL_SRC:    flow_ok = !src_bad;
               `FSEL_DST:    flow_ok = !dst_bad;
               `FSEL_EITHER: flow_ok = !src_bad || !dst_bad;
               default:      flow_ok = 1'b0;
            endcase
         end else begin
            flow_ok = !src_bad;
         end
      end else begin
         flow_ok = !src_bad;
      end
   end

   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         cnt_q      <= 8'h00;
         hdr_q      <= 8'h00;
         act_q      <= 1'b0;
         ver_bad_q  <= 1'b0;
         frag_bad_q <= 1'b0;
         set1_bad_q <= 1'b0;
         set2_bad_q <= 1'b0;
         src_bad_q  <= 1'b0;
         dst_bad_q  <= 1'b0;
      end else if (i_frm_valid) begin
         // byte counter saturates so long frames never wrap into the header again
         cnt_q      <= (pos_now_b == 8'hFF) ? 8'hFF : pos_now_b + 8'h01;
         hdr_q      <= hdr_now;
         act_q      <= act_now;
         ver_bad_q  <= ver_bad;
         frag_bad_q <= frag_bad;
         set1_bad_q <= set1_bad;
         set2_bad_q <= set2_bad;
         src_bad_q  <= src_bad;
         dst_bad_q  <= dst_bad;
      end
   end

   wire done = i_frm_valid && i_frm_eof;

   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_res_valid    <= 1'b0;
         o_proto_match  <= 1'b0;
         o_flow_match   <= 1'b0;
         o_next_hdr_pos <= 8'h00;
         o_next_stage   <= 3'h0;
         o_sum_zero     <= 1'b0;
         o_sum_fixup    <= 1'b0;
         o_sum_loc      <= 8'h00;
         o_sum_len      <= 2'h0;
         status_q       <= 6'h00;
      end else begin
         o_res_valid <= done && act_now;
         if (done && act_now) begin
            o_proto_match  <= proto_ok;
            o_flow_match   <= proto_ok && flow_ok;
            o_next_hdr_pos <= proto_ok ? hdr_now + hdr_len_q : 8'h00;
            o_next_stage   <= proto_ok ? next_stage_q : 3'h0;
            o_sum_zero     <= proto_ok && zero_en_q;
            o_sum_fixup    <= proto_ok && fixup_en_q;
            o_sum_loc      <= (proto_ok && (mode_q == `MODE_IPV4)) ? sum_loc_q : 8'h00;
            o_sum_len      <= (proto_ok && (zero_en_q || fixup_en_q)) ? sum_len_q : 2'h0;
            status_q       <= {proto_ok && flow_ok, proto_ok, set2_bad, set1_bad, frag_bad,
                               ver_bad};
         end
      end
   end

endmodule

// File: tb/ip_ach_cmp_props.sv
// concurrent checks on the ports of the ip/ach comparator
module ip_ach_cmp_props (
   // clock and reset
   input wire       i_clk_sys,
   input wire       i_reset,
   // read channels
   input wire       i_arvalid,
   input wire       o_arready,
   input wire       o_rvalid,
   input wire       i_rready,
   // frame stream
   input wire       i_frm_valid,
   input wire       i_frm_eof,
   // results
   input wire       o_res_valid,
   input wire       o_proto_match,
   input wire       o_flow_match,
   input wire [7:0] o_next_hdr_pos,
   input wire [2:0] o_next_stage,
   input wire       o_sum_zero,
   input wire       o_sum_fixup,
   input wire [7:0] o_sum_loc,
   input wire [1:0] o_sum_len
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_reset);

   sequence rd_take;
      i_arvalid && o_arready;
   endsequence
   sequence rd_done;
      !o_rvalid ##1 o_arready;
   endsequence

   res_cause_a: assert property (o_res_valid |-> $past(i_frm_valid && i_frm_eof))
      else $error("result without a closing frame byte");
   miss_clear_a: assert property (o_res_valid && !o_proto_match |->
      o_next_stage == 3'h0 && o_next_hdr_pos == 8'h00)
      else $error("pointers forwarded without a match");
   res_hold_a: assert property (!o_res_valid |->
      $stable(o_next_stage) && $stable(o_next_hdr_pos))
      else $error("result changed between results");
   flow_proto_a: assert property (o_flow_match |-> o_proto_match)
      else $error("flow match without protocol match");
   sum_gate_a: assert property (!o_proto_match |->
      !o_sum_zero && !o_sum_fixup && o_sum_loc == 8'h00)
      else $error("checksum directive without match");
   sum_len_a: assert property (o_sum_len != 2'h0 |-> o_sum_zero || o_sum_fixup)
      else $error("checksum length without directive");
   rd_resp_a: assert property (rd_take |=> o_rvalid)
      else $error("read answer late");
   rd_ready_a: assert property (o_rvalid && i_rready |=> rd_done)
      else $error("read channel not released");
endmodule

bind ip_ach_next_protocol_compare ip_ach_cmp_props chk (
   .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_arvalid(i_arvalid),
   .o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready),
   .i_frm_valid(i_frm_valid), .i_frm_eof(i_frm_eof), .o_res_valid(o_res_valid),
   .o_proto_match(o_proto_match), .o_flow_match(o_flow_match),
   .o_next_hdr_pos(o_next_hdr_pos), .o_next_stage(o_next_stage),
   .o_sum_zero(o_sum_zero), .o_sum_fixup(o_sum_fixup), .o_sum_loc(o_sum_loc),
   .o_sum_len(o_sum_len)
);

// File: tb/ip_ach_frame_src.sv
// frame byte source standing in for the preceding comparator stage
module ip_ach_frame_src (
   // clock
   input  wire logic i_clk_sys,
   // byte stream
   output logic       o_frm_valid,
   output logic [7:0] o_frm_data,
   output logic       o_frm_sof,
   output logic       o_frm_eof,
   output logic [7:0] o_hdr_pos,
   output logic       o_stage_sel
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {o_frm_valid, o_frm_sof, o_frm_eof, o_stage_sel} = 4'h0;
      o_frm_data = 8'h00;
      o_hdr_pos = 8'h00;
   end

   // gap puts an idle cycle with scrambled data between bytes
   task automatic send(input logic [7:0] f [0:31], input logic [7:0] hp, input logic sel,
                       input logic gap);
      for (int i = 0; i < 32; i++) begin
         if (gap && i > 0) begin
            @(posedge i_clk_sys);
            o_frm_valid <= 1'b0;
            o_frm_data <= ~f[i - 1];
         end
         @(posedge i_clk_sys);
         o_frm_valid <= 1'b1;
         o_frm_data <= f[i];
         o_frm_sof <= (i == 0);
         o_frm_eof <= (i == 31);
         o_hdr_pos <= hp;
         o_stage_sel <= sel;
      end
      @(posedge i_clk_sys);
      o_frm_valid <= 1'b0;
      o_frm_sof <= 1'b0;
      o_frm_eof <= 1'b0;
      o_frm_data <= ~f[31];
   endtask
endmodule

// File: tb/ip_ach_next_protocol_compare_tb_top.sv
// testbench: register access and frame results of the ip/ach comparator
`include "ip_ach_cmp_map.vh"
module ip_ach_next_protocol_compare_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] HP = 8'h02;
   localparam logic [7:0] HL = 8'h14;
   localparam logic [7:0] LOC = 8'h1A;
   logic        i_clk_sys, i_reset, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
   logic [7:0]  i_awaddr, i_araddr;
   logic [31:0] i_wdata, d;
   logic [3:0]  i_wstrb;
   logic [1:0]  r;
   logic [25:0] seen;
   logic [7:0]  fr [0:31];
   logic [2:0]  ptr [0:3] = '{3'h1, 3'h2, 3'h3, 3'h5};
   logic [7:0]  mi [0:4] = '{8'h02, 8'h08, 8'h09, 8'h0B, 8'h08};
   logic [7:0]  mv [0:4] = '{8'h65, 8'h20, 8'h01, 8'h06, 8'h40};
   logic [7:0]  sa [0:2] = '{8'h1C, 8'h14, 8'h1C};
   logic [31:0] sd [0:2] = '{32'hFFFF_FFFF, 32'h0A00_0003, 32'hFFFF_FFFE};
   wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_res_valid;
   wire         o_proto_match, o_flow_match, o_sum_zero, o_sum_fixup;
   wire  [1:0]  o_bresp, o_rresp, o_sum_len;
   wire  [31:0] o_rdata;
   wire  [7:0]  o_next_hdr_pos, o_sum_loc, frm_data, hdr_pos;
   wire  [2:0]  o_next_stage;
   wire         frm_valid, frm_sof, frm_eof, stage_sel;
   int          err_total = 0, tests_run = 0, cyc = 0;

   ip_ach_next_protocol_compare DUT (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_awaddr(i_awaddr),
      .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
      .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
      .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr),
      .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
      .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
      .i_frm_valid(frm_valid), .i_frm_data(frm_data), .i_frm_sof(frm_sof),
      .i_frm_eof(frm_eof), .i_hdr_pos(hdr_pos), .i_stage_sel(stage_sel),
      .o_res_valid(o_res_valid), .o_proto_match(o_proto_match),
      .o_flow_match(o_flow_match), .o_next_hdr_pos(o_next_hdr_pos),
      .o_next_stage(o_next_stage), .o_sum_zero(o_sum_zero), .o_sum_fixup(o_sum_fixup),
      .o_sum_loc(o_sum_loc), .o_sum_len(o_sum_len));
   ip_ach_frame_src src (
      .i_clk_sys(i_clk_sys), .o_frm_valid(frm_valid), .o_frm_data(frm_data),
      .o_frm_sof(frm_sof), .o_frm_eof(frm_eof), .o_hdr_pos(hdr_pos),
      .o_stage_sel(stage_sel));

   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end

   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         stop_test;
      end
   end

   task stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [33:0] s, input logic [33:0] e);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_clk_sys);
      i_awaddr <= a;
      i_awvalid <= 1'b1;
      i_wdata <= v;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      forever begin
         @(posedge i_clk_sys);
         if (i_awvalid && o_awready) i_awvalid <= 1'b0;
         if (i_wvalid && o_wready) i_wvalid <= 1'b0;
         if (o_bvalid === 1'b1) begin
            r = o_bresp;
            i_bready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic axi_rd(input logic [7:0] a);
      @(posedge i_clk_sys);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      forever begin
         @(posedge i_clk_sys);
         if (i_arvalid && o_arready) i_arvalid <= 1'b0;
         if (o_rvalid === 1'b1) begin
            d = o_rdata;
            r = o_rresp;
            i_rready <= 1'b0;
            break;
         end
      end
   endtask

   // ipv4 header at HP with udp following; source and destination differ
   task automatic base_frame;
      for (int i = 0; i < 32; i++) fr[i] = 8'h00;
      fr[2] = 8'h45;
      fr[11] = 8'h11;
      {fr[14], fr[15], fr[16], fr[17]} = 32'hC0A8_0001;
      {fr[18], fr[19], fr[20], fr[21]} = 32'h0A00_0002;
   endtask

   task automatic run(input logic sel, input logic g);
      src.send(fr, HP, sel, g);
      seen = '0;
      for (int n = 0; n < 8; n++) begin
         @(posedge i_clk_sys);
         if (o_res_valid === 1'b1) seen = {1'b1, o_proto_match, o_flow_match, o_next_hdr_pos,
            o_next_stage, o_sum_zero, o_sum_fixup, o_sum_loc, o_sum_len};
      end
   endtask

   function automatic logic [33:0] ex(input logic m, f, input logic [2:0] p,
                                      input logic z, x, v4);
      return {8'h00, 1'b1, m, f, m ? HP + HL : 8'h00, m ? p : 3'h0, m & z, m & x,
              (m & v4) ? LOC : 8'h00, (m & (z | x)) ? 2'h2 : 2'h0};
   endfunction

   initial begin
      {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
      {i_awaddr, i_araddr, i_wdata} = 48'h0;
      i_wstrb = 4'hF;
      i_reset = 1'b1;
      repeat (8) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      axi_rd(`REG_CTRL);
      check({r, d}, {`RESP_OKAY, 32'h0002_0000});
      axi_rd(8'h80);
      check({r, d}, {`RESP_DECERR, 32'h0000_0000});
      axi_wr(8'h80, 32'h0000_0001);
      check({32'h0, r}, {32'h0, `RESP_DECERR});
      axi_wr(`REG_FIRST, 32'h0009_FF11);
      axi_wr(`REG_POSITION, 32'h0014_0C0C);
      axi_wr(`REG_SUM_LOC, {24'h0, LOC});
      axi_wr(8'h20, 32'hC0A8_0001);
      axi_wr(8'h30, 32'hFFFF_FFFF);
      axi_rd(`REG_POSITION);
      check({r, d}, {`RESP_OKAY, 32'h0014_0C0C});
      // only byte lane 1 may change: the flow position field
      i_wstrb <= 4'h2;
      axi_wr(`REG_POSITION, 32'hFFFF_FFFF);
      i_wstrb <= 4'hF;
      axi_rd(`REG_POSITION);
      check({r, d}, {`RESP_OKAY, 32'h0014_1F0C});
      axi_wr(`REG_POSITION, 32'h0014_0C0C);
      $display("test registers done");
      base_frame;
      for (int k = 0; k < 4; k++) begin
         axi_wr(`REG_CTRL, 32'h0002_1000 | {25'h0, ptr[k], 4'h0} | k);
         run(1'b1, k[0]);
         check(34'(seen), ex(k != 1, k != 1, ptr[k], 1'b1, 1'b0, k == 0));
      end
      $display("test modes done");
      axi_wr(`REG_CTRL, 32'h0002_2050);
      for (int j = 0; j < 5; j++) begin
         base_frame;
         fr[mi[j]] = mv[j];
         run(1'b1, 1'b0);
         check(34'(seen), ex(j == 4, j == 4, 3'h5, 1'b0, 1'b1, 1'b1));
      end
      $display("test header checks done");
      base_frame;
      axi_wr(`REG_CTRL, 32'h0002_0050);
      axi_wr(8'h10, 32'hC0A8_0001);
      axi_wr(8'h14, 32'h0A00_0002);
      axi_wr(8'h18, 32'hFFFF_FFFF);
      for (int j = 0; j < 3; j++) begin
         axi_wr(sa[j], sd[j]);
         run(1'b1, 1'b0);
         check(34'(seen), ex(j != 1, j != 1, 3'h5, 1'b0, 1'b0, 1'b1));
      end
      $display("test second set done");
      for (int j = 0; j < 3; j++) begin
         axi_wr(`REG_CTRL, 32'h0002_0050 | (j << 8));
         run(1'b1, 1'b1);
         check({8'h0, seen}, ex(1'b1, j != 1, 3'h5, 1'b0, 1'b0, 1'b1));
      end
      $display("test flow select done");
      run(1'b0, 1'b0);
      check({33'h0, seen[25]}, 34'h0);
      // status still holds the last selected result: protocol and flow matched
      axi_rd(`REG_STATUS);
      check({r, d}, {`RESP_OKAY, 32'h0000_0030});
      $display("test unselected done");
      stop_test;
   end
endmodule
